// file: rtl/scdec_pkg.sv
// Package: constants and types for the card command decoder
package scdec_pkg;

  // ***********************************************
  // Command indices handled here
  // ***********************************************
  localparam logic [5:0] IDX_COND_QUERY = 6'h08;
  localparam logic [5:0] IDX_SPEC_READ = 6'h09;
  localparam logic [5:0] IDX_IDENT_READ = 6'h0a;
  localparam logic [5:0] IDX_STOP = 6'h0c;
  localparam logic [5:0] IDX_STATUS = 6'h0d;
  localparam logic [5:0] IDX_BLEN_SET = 6'h10;
  localparam logic [5:0] IDX_READ_ONE = 6'h11;
  localparam logic [5:0] IDX_READ_MULTI = 6'h12;
  localparam logic [5:0] IDX_WRITE_ONE = 6'h18;
  localparam logic [5:0] IDX_WRITE_MULTI = 6'h19;
  localparam logic [5:0] IDX_SPEC_PROG = 6'h1b;
  localparam logic [5:0] IDX_RANGE_LO = 6'h08;
  localparam logic [5:0] IDX_RANGE_HI = 6'h1b;

  // ***********************************************
  // Argument fields and reset values
  // ***********************************************
  localparam int SUPPLY_MSB = 11;
  localparam int SUPPLY_LSB = 8;
  localparam int PATTERN_MSB = 7;
  localparam int PATTERN_LSB = 0;
  localparam logic [31:0] FIXED_BLOCK_BYTES = 32'h0000_0200;
  localparam logic [31:0] BLOCK_LEN_RESET = 32'h0000_0200;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [1:0] {
    first_response_format,
    first_response_with_busy,
    second_response_format,
    seventh_response_format
  } scdec_resp_t;

  typedef enum logic [3:0] {
    act_none,
    act_cond_query,
    act_send_specific,
    act_send_identity,
    act_stop_read,
    act_send_status,
    act_set_length,
    act_read_one,
    act_read_multi,
    act_write_one,
    act_write_multi,
    act_program_specific,
    act_illegal
  } scdec_act_t;

  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
  } scdec_cmd_t;

  typedef struct packed {
    scdec_act_t action;
    scdec_resp_t fmt;
    logic illegal;
    logic [3:0] host_supply_voltage_field;
    logic [7:0] check_pattern;
    logic [31:0] address;
    logic [31:0] xfer_len;
  } scdec_ans_t;

endpackage

// file: rtl/scdec_decoder.sv
// Module: command decoder for a flash card in serial-peripheral mode
`timescale 1ns/10ps

// Summary of operation
// (R1) The condition query takes arg bits 11..8 as supply field and 7..0 as check pattern and answers in seventh format.
// (R2) The host drives the upper twenty argument bits of the condition query as zero.
// (R3) Index 9 answers in first format and then sends the specific data register.
// (R4) Index 10 answers in first format and then sends the identity register.
// (R5) Index 12 ends a multi-block read and answers in first format with busy.
// (R6) Index 13 reports status in the two-byte second format.
// (R7) On a standard-capacity card index 16 loads the whole argument as memory block length.
// (R8) On high or extended capacity cards memory access always uses 512-byte blocks.
// (R9) Index 16 always sets the lock and unlock data length.
// (R10) Index 17 reads one block of the configured length and answers in first format.
// (R11) Index 18 keeps sending blocks from the address until the stop command.
// (R12) Index 24 accepts and programs one block of the configured length.
// (R13) Index 25 accepts blocks until the host sends the stop token instead of a start token.
// (R14) Index 27 accepts a block updating only programmable specific-data bits, first format.
// (R15) Stuff and reserved argument bits never affect decoding.
// (R16) The six-bit index field is the plain binary command number.
// (R17) Unsupported or reserved indices 8..27 are answered with the illegal flag set.
module scdec_decoder #(
  parameter logic [31:0] FIXED_LEN = scdec_pkg::FIXED_BLOCK_BYTES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic high_capacity,
  input wire logic cmd_valid,
  input wire scdec_pkg::scdec_cmd_t cmd,
  input wire logic token_valid,
  input wire logic token_is_stop,
  output logic ans_valid_q,
  output scdec_pkg::scdec_ans_t ans_q,
  output logic [31:0] lock_len_q,
  output logic read_multi_q,
  output logic write_multi_q
);
  import scdec_pkg::*;

  if (FIXED_LEN == 32'h0000_0000) begin : g_bad_len
    $error("Fixed block length must be nonzero");
  end

  // ***********************************************
  // Decode
  // ***********************************************
  logic [31:0] blk_len_q;
  logic [31:0] eff_len;
  scdec_ans_t ans_d;

  // Capacity class picks the length; a later class change applies at once
  assign eff_len = high_capacity ? FIXED_LEN : blk_len_q; // R7 R8

  always_comb begin
    ans_d = '0;
    ans_d.action = act_none;
    ans_d.fmt = first_response_format;
    ans_d.address = cmd.arg;
    ans_d.xfer_len = eff_len;
    // Only the index selects; argument content never does
    unique case (cmd.index) // R15 R16
      IDX_COND_QUERY: begin
        ans_d.action = act_cond_query;
        ans_d.fmt = seventh_response_format; // R1
        ans_d.host_supply_voltage_field = cmd.arg[SUPPLY_MSB:SUPPLY_LSB]; // R1
        ans_d.check_pattern = cmd.arg[PATTERN_MSB:PATTERN_LSB]; // R1
      end
      IDX_SPEC_READ: ans_d.action = act_send_specific; // R3
      IDX_IDENT_READ: ans_d.action = act_send_identity; // R4
      IDX_STOP: begin
        ans_d.action = act_stop_read; // R5
        ans_d.fmt = first_response_with_busy; // R5
      end
      IDX_STATUS: begin
        ans_d.action = act_send_status;
        ans_d.fmt = second_response_format; // R6
      end
      IDX_BLEN_SET: ans_d.action = act_set_length;
      IDX_READ_ONE: ans_d.action = act_read_one; // R10
      IDX_READ_MULTI: ans_d.action = act_read_multi; // R11
      IDX_WRITE_ONE: ans_d.action = act_write_one; // R12
      IDX_WRITE_MULTI: ans_d.action = act_write_multi; // R13
      IDX_SPEC_PROG: ans_d.action = act_program_specific; // R14
      default: begin
        // Indices outside 8..27 belong to other decoders
        if (cmd.index >= IDX_RANGE_LO && cmd.index <= IDX_RANGE_HI) begin
          ans_d.action = act_illegal;
          ans_d.illegal = 1'b1; // R17
        end
      end
    endcase
  end

  // ***********************************************
  // Answer register
  // ***********************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ans_valid_q <= 1'b0;
      ans_q <= '0;
    end else begin
      ans_valid_q <= cmd_valid;
      if (cmd_valid) begin
        ans_q <= ans_d;
      end
    end
  end

  // ***********************************************
  // Block lengths
  // ***********************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      blk_len_q <= BLOCK_LEN_RESET;
      lock_len_q <= BLOCK_LEN_RESET;
    end else if (cmd_valid && cmd.index == IDX_BLEN_SET) begin
      blk_len_q <= cmd.arg; // R7
      lock_len_q <= cmd.arg; // R9
    end
  end

  // ***********************************************
  // Multi-block state
  // ***********************************************
  // A new start in the same cycle as an end wins, so no start is lost
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      read_multi_q <= 1'b0;
    end else if (cmd_valid && cmd.index == IDX_READ_MULTI) begin
      read_multi_q <= 1'b1; // R11
    end else if (cmd_valid && cmd.index == IDX_STOP) begin
      read_multi_q <= 1'b0; // R5 R11
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      write_multi_q <= 1'b0;
    end else if (cmd_valid && cmd.index == IDX_WRITE_MULTI) begin
      write_multi_q <= 1'b1; // R13
    end else if (token_valid && token_is_stop) begin
      write_multi_q <= 1'b0; // R13
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  a_cond_fields: assert property (@(posedge ref_clk) disable iff (srst) // R1
    cmd_valid && cmd.index == IDX_COND_QUERY |=> ans_valid_q &&
    ans_q.fmt == seventh_response_format &&
    ans_q.host_supply_voltage_field == $past(cmd.arg[11:8]) &&
    ans_q.check_pattern == $past(cmd.arg[7:0]))
    else $error("Condition query fields or format wrong");

  a_reads_first: assert property (@(posedge ref_clk) // R3 R4
    disable iff (srst)
    cmd_valid && (cmd.index == 6'h09 || cmd.index == 6'h0a) |=>
    ans_q.fmt == first_response_format && !ans_q.illegal &&
    (ans_q.action == act_send_specific || ans_q.action == act_send_identity))
    else $error("Register read answer wrong");

  a_stop_busy: assert property (@(posedge ref_clk) disable iff (srst) // R5
    cmd_valid && cmd.index == IDX_STOP |=>
    ans_q.fmt == first_response_with_busy && !read_multi_q)
    else $error("Stop did not answer with busy or end the read");

  a_status_fmt: assert property (@(posedge ref_clk) disable iff (srst) // R6
    cmd_valid && cmd.index == IDX_STATUS |=>
    ans_q.fmt == second_response_format)
    else $error("Status answer not in second format");

  a_len_load: assert property (@(posedge ref_clk) disable iff (srst) // R7 R9
    cmd_valid && cmd.index == IDX_BLEN_SET ##1
    cmd_valid && cmd.index == IDX_READ_ONE && !high_capacity |=>
    ans_q.xfer_len == $past(cmd.arg, 2) && lock_len_q == $past(cmd.arg, 2))
    else $error("Block length not loaded from argument");

  a_fixed_len: assert property (@(posedge ref_clk) disable iff (srst) // R8
    cmd_valid && high_capacity && (cmd.index == IDX_READ_ONE ||
    cmd.index == IDX_WRITE_ONE) |=> ans_q.xfer_len == FIXED_LEN)
    else $error("High capacity card used a variable length");

  a_read_hold: assert property (@(posedge ref_clk) disable iff (srst) // R11
    read_multi_q && !(cmd_valid && cmd.index == IDX_STOP) |=> read_multi_q)
    else $error("Multi-block read ended without stop");

  a_write_stop: assert property (@(posedge ref_clk) disable iff (srst) // R13
    write_multi_q && token_valid && token_is_stop &&
    !(cmd_valid && cmd.index == IDX_WRITE_MULTI) |=> !write_multi_q)
    else $error("Stop token did not end multi-block write");

  a_illegal_flag: assert property (@(posedge ref_clk) disable iff (srst) // R17
    cmd_valid && (cmd.index == 6'h0b || cmd.index == 6'h0e ||
    cmd.index == 6'h0f || cmd.index == 6'h1a ||
    (cmd.index >= 6'h13 && cmd.index <= 6'h17)) |=>
    ans_valid_q && ans_q.illegal && ans_q.action == act_illegal)
    else $error("Unsupported index not flagged illegal");

  a_prog_first: assert property (@(posedge ref_clk) disable iff (srst) // R14
    cmd_valid && cmd.index == IDX_SPEC_PROG |=>
    ans_q.action == act_program_specific && !ans_q.illegal &&
    ans_q.fmt == first_response_format)
    else $error("Specific data program decoded wrong");

  // Downstream data movers take the address from the answer only
  a_addr_pass: assert property (@(posedge ref_clk) disable iff (srst) // R10
    cmd_valid |=> ans_q.address == $past(cmd.arg))
    else $error("Command address not carried into the answer");

  // A stop token in the start cycle belongs to the run before
  a_set_wins: assert property (@(posedge ref_clk) disable iff (srst) // R13
    cmd_valid && cmd.index == IDX_WRITE_MULTI |=> write_multi_q)
    else $error("Multi-block write start was lost");

  a_lock_hold: assert property (@(posedge ref_clk) disable iff (srst) // R9
    !(cmd_valid && cmd.index == IDX_BLEN_SET) |=> $stable(lock_len_q))
    else $error("Lock length changed without a length command");

  a_none_legal: assert property (@(posedge ref_clk) disable iff (srst) // R17
    cmd_valid && (cmd.index < IDX_RANGE_LO || cmd.index > IDX_RANGE_HI) |=>
    ans_q.action == act_none && !ans_q.illegal)
    else $error("Index outside this decoder flagged or decoded");

endmodule // scdec_decoder

// file: test/scdec_host_model.sv
// Host model that issues card commands and data tokens
`timescale 1ns/10ps
module scdec_host_model (
  input wire logic ref_clk,
  output logic cmd_valid,
  output scdec_pkg::scdec_cmd_t cmd,
  output logic token_valid,
  output logic token_is_stop
);
  import scdec_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    token_valid = 1'b0;
    token_is_stop = 1'b0;
  end
  // Idle lines show the inverse so no stale value can pass as a command
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd.index = idx;
    cmd.arg = (idx == IDX_COND_QUERY) ? {20'h00000, arg[11:0]} : arg;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
  // Back-to-back pair: valid stays high so both edges take a command
  task automatic send_pair(input logic [5:0] idx0, input logic [31:0] arg0,
    input logic [5:0] idx1, input logic [31:0] arg1);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd.index = idx0;
    cmd.arg = arg0;
    @(posedge ref_clk);
    #1;
    cmd.index = idx1;
    cmd.arg = arg1;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
  task automatic send_token(input logic stop);
    @(posedge ref_clk);
    #1;
    token_valid = 1'b1;
    token_is_stop = stop;
    @(posedge ref_clk);
    #1;
    token_valid = 1'b0;
    token_is_stop = ~stop;
  endtask
endmodule // scdec_host_model

// file: test/tb_scdec_decoder.sv
// Self-checking bench for the card command decoder
`timescale 1ns/10ps
module tb_scdec_decoder;
  import scdec_pkg::*;
  logic ref_clk, srst, high_capacity, cmd_valid, token_valid, token_is_stop;
  logic ans_valid_q, read_multi_q, write_multi_q;
  logic [31:0] lock_len_q;
  scdec_cmd_t cmd;
  scdec_ans_t ans_q;
  int bad_count = 0;
  int samples_checked = 0;
  scdec_decoder u_scdec_decoder (.ref_clk(ref_clk), .srst(srst),
    .high_capacity(high_capacity), .cmd_valid(cmd_valid), .cmd(cmd),
    .token_valid(token_valid), .token_is_stop(token_is_stop),
    .ans_valid_q(ans_valid_q), .ans_q(ans_q), .lock_len_q(lock_len_q),
    .read_multi_q(read_multi_q), .write_multi_q(write_multi_q));
  scdec_host_model u_scdec_host_model (.ref_clk(ref_clk),
    .cmd_valid(cmd_valid), .cmd(cmd), .token_valid(token_valid),
    .token_is_stop(token_is_stop));
  // ***********************************************
  // Helpers
  // ***********************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  function automatic scdec_act_t want_act(input logic [5:0] i);
    case (i)
      IDX_COND_QUERY: return act_cond_query;
      IDX_SPEC_READ: return act_send_specific;
      IDX_IDENT_READ: return act_send_identity;
      IDX_STOP: return act_stop_read;
      IDX_STATUS: return act_send_status;
      IDX_BLEN_SET: return act_set_length;
      IDX_READ_ONE: return act_read_one;
      IDX_READ_MULTI: return act_read_multi;
      IDX_WRITE_ONE: return act_write_one;
      IDX_WRITE_MULTI: return act_write_multi;
      IDX_SPEC_PROG: return act_program_specific;
      default: return (i >= IDX_RANGE_LO && i <= IDX_RANGE_HI) ?
        act_illegal : act_none;
    endcase
  endfunction
  function automatic scdec_resp_t want_fmt(input logic [5:0] i);
    if (i == IDX_COND_QUERY) return seventh_response_format;
    if (i == IDX_STOP) return first_response_with_busy;
    if (i == IDX_STATUS) return second_response_format;
    return first_response_format;
  endfunction
  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_all_codes();
    scdec_act_t a;
    for (int n = 0; n < 64; n++) begin
      a = want_act(n[5:0]);
      u_scdec_host_model.send_cmd(n[5:0], 32'hffff_f000 | n);
      check(ans_valid_q, 1'b1);
      check(ans_q.action, a);
      check(ans_q.illegal, a == act_illegal);
      if (a != act_illegal && a != act_none) begin
        check(ans_q.fmt, want_fmt(n[5:0]));
      end
    end
    $display("test all_codes done");
  endtask
  task automatic t_cond_query();
    u_scdec_host_model.send_cmd(IDX_COND_QUERY, 32'h0000_03a5);
    check(ans_q.host_supply_voltage_field, 4'h3);
    check(ans_q.check_pattern, 8'ha5);
    @(posedge ref_clk);
    #1;
    check(ans_valid_q, 1'b0);
    $display("test cond_query done");
  endtask
  task automatic t_length();
    u_scdec_host_model.send_cmd(IDX_BLEN_SET, 32'h0000_0400);
    check(lock_len_q, 32'h0000_0400);
    u_scdec_host_model.send_cmd(IDX_READ_ONE, 32'h0000_1000);
    check(ans_q.xfer_len, 32'h0000_0400);
    check(ans_q.address, 32'h0000_1000);
    u_scdec_host_model.send_cmd(IDX_WRITE_ONE, 32'h0000_2000);
    check(ans_q.xfer_len, 32'h0000_0400);
    @(posedge ref_clk);
    #1;
    high_capacity = 1'b1;
    u_scdec_host_model.send_cmd(IDX_BLEN_SET, 32'h0000_0080);
    check(lock_len_q, 32'h0000_0080);
    u_scdec_host_model.send_cmd(IDX_READ_MULTI, 32'h0000_0010);
    check(ans_q.xfer_len, FIXED_BLOCK_BYTES);
    u_scdec_host_model.send_cmd(IDX_WRITE_ONE, 32'h0000_0020);
    check(ans_q.xfer_len, FIXED_BLOCK_BYTES);
    $display("test length done");
  endtask
  task automatic t_multi();
    u_scdec_host_model.send_cmd(IDX_WRITE_MULTI, 32'h0000_0040);
    check(read_multi_q, 1'b1);
    check(write_multi_q, 1'b1);
    u_scdec_host_model.send_token(1'b0);
    check(write_multi_q, 1'b1);
    u_scdec_host_model.send_token(1'b1);
    check(write_multi_q, 1'b0);
    u_scdec_host_model.send_cmd(IDX_STOP, 32'hffff_ffff);
    check(read_multi_q, 1'b0);
    check(ans_q.fmt, first_response_with_busy);
    u_scdec_host_model.send_cmd(IDX_READ_MULTI, 32'h0000_0000);
    check(read_multi_q, 1'b1);
    @(posedge ref_clk);
    #1;
    srst = 1'b1;
    @(posedge ref_clk);
    #1;
    srst = 1'b0;
    check(read_multi_q, 1'b0);
    check(write_multi_q, 1'b0);
    check(lock_len_q, BLOCK_LEN_RESET);
    $display("test multi done");
  endtask
  task automatic t_edges();
    @(posedge ref_clk);
    #1;
    high_capacity = 1'b0;
    u_scdec_host_model.send_pair(IDX_BLEN_SET, 32'h0000_0300,
      IDX_READ_ONE, 32'h0000_4000);
    check(ans_q.action, act_read_one);
    check(ans_q.xfer_len, 32'h0000_0300);
    check(ans_q.address, 32'h0000_4000);
    check(lock_len_q, 32'h0000_0300);
    fork
      u_scdec_host_model.send_cmd(IDX_WRITE_MULTI, 32'h0000_0000);
      u_scdec_host_model.send_token(1'b1);
    join
    check(write_multi_q, 1'b1);
    u_scdec_host_model.send_token(1'b1);
    check(write_multi_q, 1'b0);
    u_scdec_host_model.send_token(1'b1);
    check(write_multi_q, 1'b0);
    $display("test edges done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ***********************************************
  // Clock, reset and sequence
  // ***********************************************
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    high_capacity = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    check(ans_valid_q, 1'b0);
    check(lock_len_q, BLOCK_LEN_RESET);
    t_all_codes();
    t_cond_query();
    t_multi();
    t_length();
    t_edges();
    give_verdict();
  end
endmodule // tb_scdec_decoder
